// file: include/srap_pkg.sv
// Purpose: shared constants and types for the serial register access port
// Assumes: one system clock, serial pins sampled synchronously
// Notes: register space is 128 bytes of flip-flops
package srap_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam logic [2:0] BIT_CNT_RST = 3'h0;
    localparam logic [2:0] BIT_CNT_LAST = 3'h7;
    localparam logic [7:0] REG_RST = 8'h00;

    typedef enum logic [1:0] {
        SRAP_ST_CMD,
        SRAP_ST_WRITE,
        SRAP_ST_READ
    } srap_state_t;

    // serial pins coming from the host
    typedef struct packed {
        logic sclk;
        logic select_low;
        logic serial_in;
    } srap_pins_t;

    // pad drive for the serial output
    typedef struct packed {
        logic serial_out;
        logic serial_out_oe;
    } srap_pad_t;
endpackage : srap_pkg

// file: core/srap_port.sv
// Purpose: serial slave port giving a host read/write access to 128 control bytes
// Assumes: sclk, select_low and serial_in are synchronous to clk_sys and slow enough
//          that every serial clock level spans at least one clk_sys edge
// Notes: serial clock edges are found by comparing samples in the clk_sys domain
// Contract
// - A transfer is sixteen bits: direction bit, seven address bits, eight data bits.
// - A direction bit of one means write and zero means read.
// - The address selects one of 128 byte registers, each readable and writable.
// - Address and each data byte are taken as a whole after every eight serial clocks.
// - In a read the shifted-in data byte is ignored and no register changes.
// - In a read the register byte leaves on eight falling edges, msb first, bit zero last.
// - After the last read bit the output holds that bit while select stays low.
// - While select is high the output is released and the pull-up holds it high.
// - With select still low and clocking on, the address increments to the next register.
// - In a burst write a further byte is taken every eight serial clocks.
module srap_port #(
    parameter int NREGS = 128
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire srap_pkg::srap_pins_t pins,
    output srap_pkg::srap_pad_t pad,
    output logic [srap_pkg::DATA_W-1:0] wr_data,
    output logic [srap_pkg::ADDR_W-1:0] wr_addr,
    output logic wr_strobe
);
    import srap_pkg::*;

    logic sclk_q;
    logic rise;
    logic fall;
    logic active;
    srap_state_t state_q;
    logic [2:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] tx_q;
    logic tx_ok_q;
    logic [DATA_W-1:0] regs_q [NREGS];
    logic [7:0] byte_in;

    assign active = !pins.select_low;
    assign rise = active && pins.sclk && !sclk_q;
    assign fall = active && !pins.sclk && sclk_q;
    assign byte_in = {shift_q[6:0], pins.serial_in};

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= pins.sclk;
        end
    end

    // bit counter and framing
    always_ff @(posedge clk_sys) begin
        if (rst || !active) begin
            bit_cnt_q <= BIT_CNT_RST;
            shift_q <= REG_RST;
            state_q <= SRAP_ST_CMD;
        end else if (rise) begin
            shift_q <= byte_in;
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == BIT_CNT_LAST && state_q == SRAP_ST_CMD) begin
                state_q <= byte_in[7] ? SRAP_ST_WRITE : SRAP_ST_READ;
            end
        end
    end

    // address: loaded from the command byte, bumped after each data byte
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            addr_q <= '0;
        end else if (rise && bit_cnt_q == BIT_CNT_LAST) begin
            case (state_q)
                SRAP_ST_CMD: addr_q <= byte_in[ADDR_W-1:0];
                SRAP_ST_WRITE, SRAP_ST_READ: addr_q <= addr_q + 7'h01;
                default: addr_q <= addr_q;
            endcase
        end
    end

    // register space; writes only from a completed write byte
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < NREGS; i++) begin
                regs_q[i] <= REG_RST;
            end
            wr_strobe <= 1'b0;
            wr_data <= REG_RST;
            wr_addr <= '0;
        end else begin
            wr_strobe <= 1'b0;
            // read phase never touches storage
            if (active && rise && bit_cnt_q == BIT_CNT_LAST && state_q == SRAP_ST_WRITE) begin
                regs_q[addr_q] <= byte_in;
                wr_strobe <= 1'b1;
                wr_data <= byte_in;
                wr_addr <= addr_q;
            end
        end
    end

    // read shifter: loads on the falling edge that opens each read byte
    always_ff @(posedge clk_sys) begin
        if (rst || !active) begin
            tx_q <= REG_RST;
            tx_ok_q <= 1'b0;
        end else if (fall && state_q == SRAP_ST_READ) begin
            if (bit_cnt_q == BIT_CNT_RST) begin
                tx_q <= regs_q[addr_q];
            end else begin
                tx_q <= {tx_q[6:0], 1'b0};
            end
            tx_ok_q <= 1'b1;
        end
    end

    // pad: released high when deselected, holds bit zero after the byte
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pad <= '{serial_out: 1'b1, serial_out_oe: 1'b0};
        end else if (!active) begin
            pad <= '{serial_out: 1'b1, serial_out_oe: 1'b0};
        end else if (fall && state_q == SRAP_ST_READ) begin
            pad <= '{serial_out: (bit_cnt_q == BIT_CNT_RST) ? regs_q[addr_q][7] : tx_q[6],
                     serial_out_oe: 1'b1};
        end else begin
            pad <= '{serial_out: pad.serial_out, serial_out_oe: tx_ok_q};
        end
    end
endmodule : srap_port

// file: tb/srap_chk.sv
// Purpose: port checker; Assumes: pins sync to clk_sys; Notes: bound into srap_port
module srap_chk (input wire logic clk_sys, input wire logic rst,
    input wire srap_pkg::srap_pins_t pins, input wire srap_pkg::srap_pad_t pad,
    input wire logic [7:0] wr_data, input wire logic [6:0] wr_addr, input wire logic wr_strobe);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence fall_s; $past(pins.sclk, 2) && !$past(pins.sclk); endsequence
    a_out_release: assert property (pins.select_low |=> pad == 2'h2) else $error("no release");
    a_oe_select: assert property (pad.serial_out_oe |-> !$past(pins.select_low)) else $error("oe");
    a_strobe_once: assert property (wr_strobe |=> !wr_strobe) else $error("long strobe");
    a_strobe_rise: assert property (wr_strobe |-> $past(pins.sclk) && !$past(pins.sclk, 2)) else $error("edge");
    a_out_on_fall: assert property ($changed(pad.serial_out) && !$past(pins.select_low) |-> fall_s) else $error("out");
    a_oe_hold: assert property (pad.serial_out_oe && !pins.select_low |=> pad.serial_out_oe) else $error("oe drop");
    a_read_quiet: assert property (pad.serial_out_oe |-> !wr_strobe) else $error("write in read");
    a_data_hold: assert property (!wr_strobe |-> $stable({wr_addr, wr_data})) else $error("wr moved");
endmodule : srap_chk
bind srap_port srap_chk u_chk (.clk_sys, .rst, .pins, .pad, .wr_data, .wr_addr, .wr_strobe);

// file: tb/srap_host.sv
// Purpose: host model; Assumes: sclk half period three clk_sys cycles; Notes: sclk idles low
module srap_host (input wire logic clk_sys, output srap_pkg::srap_pins_t pins,
    input wire srap_pkg::srap_pad_t pad);
    timeunit 1ns; timeprecision 1ns;
    initial pins = 3'h2;
    task shut;
        repeat (4) @(posedge clk_sys) pins <= 3'h2;
    endtask : shut
    task xb(input logic [7:0] tx, input int n, output logic [7:0] rx);
        for (int i = 7; i > 7 - n; i--) begin
            @(posedge clk_sys) pins <= {2'h0, tx[i]};
            repeat (3) @(negedge clk_sys);
            rx[i] = pad.serial_out;
            repeat (3) @(posedge clk_sys) pins.sclk <= 1'h1;
        end
    endtask : xb
endmodule : srap_host

// file: tb/tb_top.sv
// Purpose: port bench; Assumes: host model drives pins; Notes: strobes are queued
module tb_top;
    timeunit 1ns; timeprecision 1ns;
    logic clk_sys = 1'h0, rst = 1'h1, wr_strobe;
    logic [7:0] wr_data, r; logic [6:0] wr_addr;
    logic [14:0] q[$];
    int error_cnt = 0, samples_checked = 0, cyc = 0;
    srap_pkg::srap_pins_t pins;
    srap_pkg::srap_pad_t pad;
    srap_port u_srap_port (.clk_sys(clk_sys), .rst(rst), .pins(pins), .pad(pad),
        .wr_data(wr_data), .wr_addr(wr_addr), .wr_strobe(wr_strobe));
    srap_host u_srap_host (.clk_sys(clk_sys), .pins(pins), .pad(pad));
    initial forever #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (wr_strobe === 1'h1) q.push_back({wr_addr, wr_data});
    always @(posedge clk_sys) if (++cyc == 3000) close_out;
    task chk(input string nm, input logic [14:0] e, g);
        samples_checked++;
        if (g !== e) begin error_cnt++; $display("wrong value %s exp %h got %h", nm, e, g); end
    endtask : chk
    task close_out;
        error_cnt += int'(cyc >= 3000);
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out
    task t_wr;
        u_srap_host.xb(8'hFF, 5, r); u_srap_host.shut;
        u_srap_host.xb(8'hFF, 8, r); u_srap_host.xb(8'h3C, 8, r);
        u_srap_host.xb(8'h96, 8, r); u_srap_host.shut;
        chk("burst0", {7'h7F, 8'h3C}, q[0]);
        chk("burst1", {7'h00, 8'h96}, q[1]);
    endtask : t_wr
    task t_rd;
        u_srap_host.xb(8'h7F, 8, r); u_srap_host.xb(8'hA5, 8, r);
        chk("read0", 15'h003C, r);
        u_srap_host.xb(8'h5A, 8, r); chk("read1", 15'h0096, r);
        chk("read_no_write", 15'h0002, 15'(q.size()));
        chk("hold", 15'h0000, pad.serial_out);
        u_srap_host.shut;
        chk("release", 15'h0002, pad);
    endtask : t_rd
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'h0; t_wr; t_rd; close_out;
    end
endmodule : tb_top
